// [offchip_bus_unit.sv]
// off-chip bus unit: bus cycles, windows, chip selects, ready and hold arbitration
module offchip_bus_unit import offchip_bus_pkg::*; (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // core request, held until o_rsp_valid
    input wire logic i_req_valid,
    input wire logic [ADDR_W-1:0] i_req_addr,
    input wire logic i_req_write,
    input wire logic i_req_byte,
    input wire logic [DATA_W-1:0] i_req_wdata,
    output logic o_rsp_valid,
    output logic o_rsp_err,
    output logic [DATA_W-1:0] o_rsp_rdata,
    // configuration
    input wire logic i_single_chip,
    input wire logic [15:0] i_system_config_reg,
    input wire logic [1:0] i_seg_size,
    input wire bus_cfg_t i_default_bus_config,
    input wire bus_cfg_t [NUM_WIN-1:0] i_window_bus_config,
    input wire win_range_t [NUM_WIN-1:0] i_window_range_select,
    input wire logic i_arbitration_enable,
    input wire logic i_ack_pin_direction_bit,
    // bus pins
    input wire logic [15:0] i_first_bus_port,
    output bus_pins_t o_pins,
    input wire logic i_ready_n,
    // arbitration pins
    input wire logic i_hold_n,
    input wire logic i_hold_acknowledge_n,
    output logic o_hold_acknowledge_n,
    output logic o_hold_acknowledge_oe,
    output logic o_bus_request_out_n
);
    bus_state_t st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q, rdata_q;
    logic write_q, byte_q, split_q, second_q, cap_q, rsp_q, err_q;
    bus_cfg_t cfg_q;
    logic [2:0] region_q;
    bus_pins_t pins_q, pins_d;
    logic ack_n_q, ack_oe_q, bus_request_out_n_q;

    // decode
    wire [ADDR_W-1:0] dec_addr = (st_q == ST_IDLE) ? i_req_addr : addr_q;
    wire [2:0] region_w;
    wire [NUM_WIN-1:0] win_en_w;
    genvar k;
    generate
        for (k = 0; k < NUM_WIN; k++) begin : g_en
            assign win_en_w[k] = i_window_bus_config[k].win_en;
        end
    endgenerate

    window_select #(.NUM(NUM_WIN)) u_win (
        .i_addr(dec_addr),
        .i_range(i_window_range_select),
        .i_en(win_en_w),
        .o_region(region_w)
    );

    wire bus_cfg_t cfg_sel = (region_w == 3'h0) ? i_default_bus_config
        : i_window_bus_config[2'(region_w - 3'h1)]; // [RQ4] [RQ6]

    // arbitration
    wire arb_on = i_arbitration_enable; // [RQ10]
    wire slave = arb_on && i_ack_pin_direction_bit; // [RQ12]
    wire granted = !slave || !i_hold_acknowledge_n;
    wire hold_req = arb_on && !slave && !i_hold_n;
    // a pending request blocks retake until the response pulse has passed
    wire take = (st_q == ST_IDLE) && i_req_valid && !rsp_q && granted && !hold_req;
    wire ext_take = take && !i_single_chip; // [RQ1]
    wire odd_take = take && i_single_chip; // [RQ1]

    wire is16 = cfg_q.mode[1];
    wire ismux = cfg_q.mode[0];
    wire [ADDR_W-1:0] eff_addr = {addr_q[ADDR_W-1:1], addr_q[0] | second_q};
    wire more = split_q && !second_q;
    wire strobe_end = (st_q == ST_STROBE && cnt_q == 4'h0 && !cfg_q.ready_en)
        || (st_q == ST_READY && !i_ready_n);
    wire done = (st_q == ST_TRI) && (cnt_q == 4'h0) && !more;

    // sequencer
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        case (st_q)
            ST_IDLE: begin
                if (hold_req) begin
                    st_d = ST_HOLD; // [RQ17]
                end else if (ext_take) begin
                    st_d = ST_ALE;
                    cnt_d = {3'h0, cfg_sel.ale_long}; // [RQ3]
                end
            end
            ST_ALE: begin
                if (cnt_q != 4'h0) begin
                    cnt_d = cnt_q - 4'h1;
                end else if (cfg_q.rw_dly) begin
                    st_d = ST_DELAY; // [RQ3]
                end else begin
                    st_d = ST_STROBE;
                    cnt_d = cfg_q.wait_cnt; // [RQ3]
                end
            end
            ST_DELAY: begin
                st_d = ST_STROBE;
                cnt_d = cfg_q.wait_cnt;
            end
            ST_STROBE: begin
                if (cnt_q != 4'h0) begin
                    cnt_d = cnt_q - 4'h1;
                end else if (cfg_q.ready_en) begin
                    st_d = ST_READY; // [RQ9]
                end else begin
                    st_d = ST_TRI;
                    cnt_d = {3'h0, cfg_q.tri_dly};
                end
            end
            ST_READY: begin
                if (!i_ready_n) begin
                    st_d = ST_TRI; // [RQ16]
                    cnt_d = {3'h0, cfg_q.tri_dly}; // [RQ3]
                end
            end
            ST_TRI: begin
                if (cnt_q != 4'h0) begin
                    cnt_d = cnt_q - 4'h1;
                end else if (more) begin
                    st_d = ST_ALE; // [RQ15]
                    cnt_d = {3'h0, cfg_q.ale_long};
                end else begin
                    st_d = ST_IDLE;
                end
            end
            ST_HOLD: begin
                if (!hold_req)
                    st_d = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st_q <= ST_IDLE;
            cnt_q <= 4'h0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // access context; an 8-bit bus splits a word into low then high byte
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            addr_q <= '0;
            wdata_q <= '0;
            write_q <= 1'b0;
            byte_q <= 1'b0;
            split_q <= 1'b0;
            cfg_q <= '0;
            region_q <= 3'h0;
        end else if (ext_take) begin
            addr_q <= i_req_addr;
            wdata_q <= i_req_wdata;
            write_q <= i_req_write;
            byte_q <= i_req_byte;
            split_q <= !i_req_byte && !cfg_sel.mode[1]; // [RQ15]
            cfg_q <= cfg_sel;
            region_q <= region_w;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            second_q <= 1'b0;
            cap_q <= 1'b0;
            rsp_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            cap_q <= strobe_end;
            rsp_q <= done || odd_take;
            err_q <= odd_take;
            if (ext_take)
                second_q <= 1'b0;
            else if (st_q == ST_TRI && cnt_q == 4'h0 && more)
                second_q <= 1'b1;
            // pins lag the state by one cycle, so data is taken one cycle late
            if (ext_take) begin
                rdata_q <= '0;
            end else if (cap_q && !write_q) begin
                if (!is16 && second_q)
                    rdata_q[15:8] <= i_first_bus_port[7:0];
                else if (!is16 || (byte_q && !addr_q[0]))
                    rdata_q[7:0] <= i_first_bus_port[7:0];
                else if (byte_q)
                    rdata_q[7:0] <= i_first_bus_port[15:8]; // [RQ15]
                else
                    rdata_q <= i_first_bus_port;
            end
        end
    end

    // pin drive
    wire active = st_q inside {ST_ALE, ST_DELAY, ST_STROBE, ST_READY, ST_TRI};
    wire data_ph = st_q inside {ST_DELAY, ST_STROBE, ST_READY};
    wire strobe_on = st_q inside {ST_STROBE, ST_READY};
    wire [1:0] lanes = !is16 ? 2'b01 : (!byte_q ? 2'b11 : (addr_q[0] ? 2'b10 : 2'b01));
    wire [15:0] lane_oe = {{8{lanes[1]}}, {8{lanes[0]}}};
    wire [15:0] wlane = !is16 ? {8'h00, second_q ? wdata_q[15:8] : wdata_q[7:0]}
        : (byte_q ? {wdata_q[7:0], wdata_q[7:0]} : wdata_q);
    wire own = (st_q != ST_HOLD) && granted; // [RQ17]
    wire unlatched = i_system_config_reg[UNLATCHED_SELECT_CFG];
    // unlatched selects glitch with the address, latched ones hold for the cycle
    wire [NUM_CS-1:0] cs_w = unlatched ? cs_active_n(region_w, cfg_sel.cs_en) // [RQ8]
        : (active ? cs_active_n(region_q, cfg_q.cs_en) : CS_IDLE); // [RQ7]

    always_comb begin
        pins_d = PINS_RST;
        pins_d.ctrl_oe = own;
        pins_d.seg = eff_addr[23:16] & seg_mask(i_seg_size); // [RQ13]
        pins_d.second_bus_port = eff_addr[15:0];
        if (own) begin
            pins_d.cs_n = cs_w;
            if (active) begin
                pins_d.seg_oe = seg_mask(i_seg_size); // [RQ13]
                pins_d.second_bus_port_oe = !ismux; // [RQ2]
                pins_d.ale = (st_q == ST_ALE);
                pins_d.rd_n = !(strobe_on && !write_q);
                pins_d.wr_n = !(strobe_on && write_q);
                pins_d.bhe_n = !(lanes[1] && is16);
            end
            if (st_q == ST_ALE && ismux) begin
                pins_d.first_bus_port = eff_addr[15:0]; // [RQ2]
                pins_d.first_bus_port_oe = 16'hffff;
            end else if (data_ph && write_q) begin
                pins_d.first_bus_port = wlane; // [RQ2]
                pins_d.first_bus_port_oe = lane_oe;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pins_q <= PINS_RST;
            ack_n_q <= 1'b1;
            ack_oe_q <= 1'b1; // [RQ11]
            bus_request_out_n_q <= 1'b1;
        end else begin
            pins_q <= pins_d;
            ack_n_q <= !(st_q == ST_HOLD); // [RQ17]
            ack_oe_q <= !i_ack_pin_direction_bit; // [RQ12]
            bus_request_out_n_q <= !(arb_on && i_req_valid && !rsp_q
                && (slave ? i_hold_acknowledge_n : (st_q == ST_HOLD))); // [RQ10]
        end
    end

    assign o_pins = pins_q;
    assign o_hold_acknowledge_n = ack_n_q;
    assign o_hold_acknowledge_oe = ack_oe_q;
    assign o_bus_request_out_n = bus_request_out_n_q;
    assign o_rsp_valid = rsp_q;
    assign o_rsp_err = err_q;
    assign o_rsp_rdata = rdata_q;

    // checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    a_single_chip_err: assert property (odd_take |=> o_rsp_valid && o_rsp_err && !o_pins.ale) // [RQ1]
        else $error("single-chip request did not end in error");
    a_demux_addr: assert property (strobe_on && !ismux |=> o_pins.second_bus_port_oe) // [RQ2]
        else $error("demux cycle without address on second port");
    a_ale_short: assert property ($rose(st_q == ST_ALE) && !cfg_q.ale_long |=> st_q != ST_ALE) // [RQ3]
        else $error("short latch strobe longer than one cycle");
    a_one_select: assert property ($countones(~o_pins.cs_n) <= 1) // [RQ7]
        else $error("more than one chip select active");
    a_ready_wait: assert property (st_q == ST_READY && i_ready_n |=> st_q == ST_READY) // [RQ16]
        else $error("ready wait left without ready");
    a_hold_float: assert property (st_q == ST_HOLD |=> o_pins.first_bus_port_oe == 16'h0000
        && !o_pins.ctrl_oe && !o_hold_acknowledge_n) // [RQ17]
        else $error("hold without floated bus and acknowledge");
    a_hold_finish: assert property (done && hold_req ##1 hold_req |=> st_q == ST_HOLD) // [RQ17]
        else $error("hold not taken once the cycle ended");
    a_slave_input: assert property (i_ack_pin_direction_bit |=> !o_hold_acknowledge_oe) // [RQ12]
        else $error("acknowledge pin driven in slave mode");
    a_seg_none: assert property ($past(i_seg_size) == SEG_64K |-> o_pins.seg_oe == 8'h00) // [RQ13]
        else $error("segment lines driven in 64 Kbyte space");
    a_word_split: assert property (ext_take && !i_req_byte && !cfg_sel.mode[1]
        |=> split_q && !second_q) // [RQ15]
        else $error("8-bit word access not split");

    c_hold: cover property (st_q == ST_HOLD ##1 st_q == ST_IDLE);
    c_split: cover property (second_q && done);
    c_ready: cover property (st_q == ST_READY && i_ready_n ##1 !i_ready_n);
endmodule

// [offchip_bus_pkg.sv]
// constants, types and helpers shared by the off-chip bus unit
// Notes on behaviour
// RQ1: single-chip mode makes no external access; four mux/demux 8/16-bit external modes
// RQ2: demux puts address on second port, data on first; mux shares first port
// RQ3: cycle time, tri-state time, latch strobe length and read/write delay are programmable
// RQ4: four address windows, each a range select plus a bus configuration
// RQ5: fourth window beats third, second beats first where windows overlap
// RQ6: accesses outside every window use the default bus configuration
// RQ7: five active-low chip selects, one per window plus the default region
// RQ8: system config bit 6 set makes chip selects follow the address unfiltered
// RQ9: a ready input stretches accesses to slow memories
// RQ10: arbitration enable hands request, acknowledge and hold pins to the unit
// RQ11: after reset the unit is arbitration master, acknowledge pin an output
// RQ12: acknowledge pin direction bit at 1 selects slave mode, pin becomes input
// RQ13: address space size sets segment lines driven: 8, 4, 2 or none
// RQ14: software limits segment lines to four when the CAN pins are needed
// RQ15: every location takes both byte and word accesses, external ones too; word accesses at odd addresses are not realigned
// RQ16: with ready enabled, wait states run until the device signals ready
// RQ17: on hold the master ends its cycle, floats the bus, then acknowledges
package offchip_bus_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int NUM_WIN = 4;
    localparam int NUM_CS = 5;
    localparam int WIN_GRAIN = 12;
    localparam int UNLATCHED_SELECT_CFG = 6;
    // mode bit 0 selects multiplexed, bit 1 selects 16-bit data
    localparam logic [1:0] MODE_DEMUX8 = 2'h0;
    localparam logic [1:0] MODE_MUX8 = 2'h1;
    localparam logic [1:0] MODE_DEMUX16 = 2'h2;
    localparam logic [1:0] MODE_MUX16 = 2'h3;
    localparam logic [1:0] SEG_16M = 2'h0;
    localparam logic [1:0] SEG_1M = 2'h1;
    localparam logic [1:0] SEG_256K = 2'h2;
    localparam logic [1:0] SEG_64K = 2'h3;
    localparam logic [NUM_CS-1:0] CS_IDLE = 5'h1f;

    typedef struct packed {
        logic win_en;
        logic [1:0] mode;
        logic [3:0] wait_cnt;
        logic ale_long;
        logic rw_dly;
        logic tri_dly;
        logic ready_en;
        logic cs_en;
    } bus_cfg_t;

    // window covers 4 Kbyte shifted left by size, aligned on base
    typedef struct packed {
        logic [11:0] base;
        logic [3:0] size;
    } win_range_t;

    typedef struct packed {
        logic [15:0] first_bus_port;
        logic [15:0] first_bus_port_oe;
        logic [15:0] second_bus_port;
        logic second_bus_port_oe;
        logic [7:0] seg;
        logic [7:0] seg_oe;
        logic ale;
        logic rd_n;
        logic wr_n;
        logic bhe_n;
        logic [NUM_CS-1:0] cs_n;
        logic ctrl_oe;
    } bus_pins_t;

    localparam bus_pins_t PINS_RST = '{first_bus_port: 16'h0000, first_bus_port_oe: 16'h0000, second_bus_port: 16'h0000,
        second_bus_port_oe: 1'b0, seg: 8'h00, seg_oe: 8'h00, ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1,
        bhe_n: 1'b1, cs_n: CS_IDLE, ctrl_oe: 1'b1};

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ALE = 3'b001,
        ST_DELAY = 3'b010,
        ST_STROBE = 3'b011,
        ST_READY = 3'b100,
        ST_TRI = 3'b101,
        ST_HOLD = 3'b110
    } bus_state_t;

    function automatic logic [7:0] seg_mask(input logic [1:0] size);
        case (size)
            SEG_1M: seg_mask = 8'h0f;
            SEG_256K: seg_mask = 8'h03;
            SEG_64K: seg_mask = 8'h00;
            default: seg_mask = 8'hff;
        endcase
    endfunction

    function automatic logic [NUM_CS-1:0] cs_active_n(input logic [2:0] region, input logic en);
        cs_active_n = CS_IDLE;
        if (en && region < 3'(NUM_CS))
            cs_active_n[region] = 1'b0;
    endfunction
endpackage

// [window_select.sv]
// address window decoder with hierarchical priority
module window_select import offchip_bus_pkg::*; #(
    parameter int NUM = NUM_WIN
) (
    // address under decode
    input wire logic [ADDR_W-1:0] i_addr,
    // window ranges and enables
    input wire win_range_t [NUM-1:0] i_range,
    input wire logic [NUM-1:0] i_en,
    // 0 is the default region, k+1 is window k
    output logic [2:0] o_region
);
    logic [NUM-1:0] hit;

    genvar k;
    generate
        for (k = 0; k < NUM; k++) begin : g_win
            wire [11:0] mask = ~((12'h001 << i_range[k].size) - 12'h001);
            assign hit[k] = i_en[k] && (((i_addr[ADDR_W-1:WIN_GRAIN] ^ i_range[k].base) & mask)
                == 12'h000); // [RQ4]
        end
    endgenerate

    // later windows override earlier ones, so the fourth wins over all
    always_comb begin
        o_region = 3'h0; // [RQ6]
        for (int i = 0; i < NUM; i++) begin
            if (hit[i])
                o_region = 3'(i + 1); // [RQ5]
        end
    end
endmodule

// [ext_mem_model.sv]
// far-side memory that answers the off-chip bus pins, with a ready line
module ext_mem_model import offchip_bus_pkg::*; (
    // clock
    input wire logic i_clk,
    // pins from the unit and setup
    input wire bus_pins_t i_pins,
    input wire logic i_wide,
    input wire logic [3:0] i_wait,
    // answer lines
    output logic [15:0] o_data,
    output logic o_ready_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    logic [7:0] a_q = 8'h00;
    logic [15:0] last_q = 16'h0000;
    logic rd_q = 1'b0;
    logic [3:0] cnt_q = 4'h0;
    wire strobe = !i_pins.rd_n || !i_pins.wr_n;
    wire [7:0] a_lo = {a_q[7:1], 1'b0};
    wire [7:0] a_hi = {a_q[7:1], 1'b1};
    wire [15:0] rd_w = i_wide ? {mem[a_hi], mem[a_lo]} : {mem[a_q], mem[a_q]};
    // data held one cycle past the read strobe, then released
    wire drv = !i_pins.rd_n || rd_q;
    // a released line shows the inverse, so a stale value never passes
    assign o_data = drv ? rd_w : ~last_q;
    // ready only once read data stands or the write is taken
    assign o_ready_n = !(strobe && cnt_q >= i_wait);
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    end
    always @(posedge i_clk) begin
        rd_q <= !i_pins.rd_n;
        cnt_q <= !strobe ? 4'h0 : cnt_q + 4'(cnt_q != 4'hf);
        if (drv) last_q <= rd_w;
        if (i_pins.ale) a_q <= i_pins.second_bus_port_oe ? i_pins.second_bus_port[7:0] : i_pins.first_bus_port[7:0];
        if (!i_pins.wr_n) begin
            if (!i_wide) mem[a_q] <= i_pins.first_bus_port[7:0];
            else begin
                if (!i_pins.bhe_n) mem[a_hi] <= i_pins.first_bus_port[15:8];
                if (!a_q[0]) mem[a_lo] <= i_pins.first_bus_port[7:0];
            end
        end
    end
endmodule

// [external_bus_controller_tb.sv]
// self-checking bench for the off-chip bus unit
module external_bus_controller_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import offchip_bus_pkg::*;
    typedef struct packed {
        logic err; logic dchk; logic [15:0] d;
        logic [4:0] cs; logic [7:0] seg; logic p1;
    } exp_t;
    logic i_clk = 1'b0, i_reset = 1'b1, i_req_valid = 1'b0, i_req_write = 1'b0;
    logic i_req_byte = 1'b0, i_single_chip = 1'b0, i_arbitration_enable = 1'b0;
    logic i_ack_pin_direction_bit = 1'b0, i_hold_n = 1'b1, i_hold_acknowledge_n = 1'b1;
    logic [ADDR_W-1:0] i_req_addr = 24'h000000;
    logic [DATA_W-1:0] i_req_wdata = 16'h0000, o_rsp_rdata, i_first_bus_port;
    logic [15:0] i_system_config_reg = 16'h0000;
    logic [1:0] i_seg_size = SEG_16M;
    bus_cfg_t i_default_bus_config = '0;
    bus_cfg_t [NUM_WIN-1:0] i_window_bus_config = '0;
    win_range_t [NUM_WIN-1:0] i_window_range_select = '0;
    bus_pins_t o_pins;
    logic i_ready_n, o_rsp_valid, o_rsp_err, o_bus_request_out_n;
    logic o_hold_acknowledge_n, o_hold_acknowledge_oe, wide = 1'b1;
    logic [3:0] wait_n = 4'h0;
    logic [6:0] t = 7'h00;
    exp_t q[$];
    exp_t ex, tp;
    logic [7:0] ref_m [256];
    logic [4:0] cs_acc = CS_IDLE;
    logic [7:0] seg_acc = 8'h00;
    logic p1_acc = 1'b0;
    logic [31:0] seed = 32'h0001420d;
    logic [23:0] wa [5] = '{24'h030040, 24'h010040, 24'h011040, 24'h021040, 24'h020040};
    logic [7:0] segx [4] = '{8'hff, 8'h0f, 8'h03, 8'h00};
    int n_fail = 0, n_checks = 0, cyc = 0, lat = 0, base = 0;

    offchip_bus_unit dut_u (.i_clk, .i_reset, .i_req_valid, .i_req_addr, .i_req_write,
        .i_req_byte, .i_req_wdata, .o_rsp_valid, .o_rsp_err, .o_rsp_rdata, .i_single_chip,
        .i_system_config_reg, .i_seg_size, .i_default_bus_config, .i_window_bus_config,
        .i_window_range_select, .i_arbitration_enable, .i_ack_pin_direction_bit,
        .i_first_bus_port, .o_pins, .i_ready_n, .i_hold_n, .i_hold_acknowledge_n,
        .o_hold_acknowledge_n, .o_hold_acknowledge_oe, .o_bus_request_out_n);
    ext_mem_model mem_u (.i_clk, .i_pins(o_pins), .i_wide(wide), .i_wait(wait_n),
        .o_data(i_first_bus_port), .o_ready_n(i_ready_n));

    always #2.5 i_clk = ~i_clk;

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function automatic bus_cfg_t mk(logic w, logic [1:0] m, logic [6:0] x, logic rdy);
        return '{w, m, x[3:0], x[4], x[5], x[6], rdy, 1'b1};
    endfunction
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // one access, entered at a falling edge; request held until the answer
    task automatic acc(logic [23:0] a, logic w, logic b, logic [15:0] d);
        exp_t x;
        int n;
        x = tp;
        x.dchk = !w && !tp.err;
        x.d = b ? {8'h00, ref_m[a[7:0]]} : {ref_m[a[7:0] | 8'h01], ref_m[a[7:0] & 8'hfe]};
        if (w && !tp.err && b) ref_m[a[7:0]] = d[7:0];
        if (w && !tp.err && !b) {ref_m[a[7:0] | 8'h01], ref_m[a[7:0] & 8'hfe]} = d;
        q.push_back(x);
        i_req_addr = a;
        i_req_write = w;
        i_req_byte = b;
        i_req_wdata = d;
        i_req_valid = 1'b1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_rsp_valid !== 1'b1 && n < 300);
        chk("rsp_valid", 16'h0001, {15'h0000, o_rsp_valid});
        lat = n;
        @(negedge i_clk);
        i_req_valid = 1'b0;
        @(negedge i_clk);
    endtask

    // result watcher: pins seen during a request are folded and compared at the answer
    always @(posedge i_clk) begin
        if (o_rsp_valid === 1'b1) begin
            ex = q.size() > 0 ? q.pop_front() : '0;
            chk("rsp_err", {15'h0000, ex.err}, {15'h0000, o_rsp_err});
            if (ex.dchk) chk("rdata", ex.d, o_rsp_rdata);
            chk("cs_n", {11'h000, ex.cs}, {11'h000, cs_acc});
            chk("seg_oe", {8'h00, ex.seg}, {8'h00, seg_acc});
            chk("second_bus_port_oe", {15'h0000, ex.p1}, {15'h0000, p1_acc});
            cs_acc = CS_IDLE;
            seg_acc = 8'h00;
            p1_acc = 1'b0;
        end else if (i_req_valid) begin
            cs_acc = cs_acc & o_pins.cs_n;
            seg_acc = seg_acc | o_pins.seg_oe;
            p1_acc = p1_acc | o_pins.second_bus_port_oe;
        end
    end
    // a hang ends the run as a mismatch
    always @(posedge i_clk) begin
        cyc++;
        if (cyc >= 20000) begin
            n_fail++;
            test_done();
        end
    end

    initial begin
        for (int i = 0; i < 256; i++) ref_m[i] = 8'h00;
        tp = '{1'b0, 1'b0, 16'h0000, 5'h1e, 8'hff, 1'b1};
        repeat (20) @(posedge i_clk);
        @(negedge i_clk);
        i_reset = 1'b0;
        @(negedge i_clk);
        chk("ack_oe", 16'h0001, {15'h0000, o_hold_acknowledge_oe});
        chk("bus_request_out_n", 16'h0001, {15'h0000, o_bus_request_out_n});
        for (int m = 0; m < 4; m++) begin
            wide = m[1];
            tp.p1 = !m[0];
            i_default_bus_config = mk(1'b0, 2'(m), 7'h00, 1'b0);
            acc(24'h030010, 1'b1, 1'b0, 16'(rnd()));
            base = lat;
            t = 7'(rnd());
            i_default_bus_config = mk(1'b0, 2'(m), t, 1'b0);
            acc(24'h030010, 1'b1, 1'b0, 16'(rnd()));
            if (m[1]) chk("latency", 16'(base + t[3:0] + t[4] + t[5] + t[6]), 16'(lat));
            acc(24'h030013, 1'b1, 1'b1, 16'(rnd()));
            acc(24'h030010, 1'b0, 1'b0, 16'h0000);
            acc(24'h030012, 1'b0, 1'b0, 16'h0000);
            acc(24'h030013, 1'b0, 1'b1, 16'h0000);
        end
        $display("test modes done");
        wide = 1'b1;
        tp.p1 = 1'b1;
        i_default_bus_config = mk(1'b0, MODE_DEMUX16, 7'h00, 1'b0);
        for (int k = 0; k < 4; k++) i_window_bus_config[k] = mk(1'b1, MODE_DEMUX16, 7'h00, 1'b0);
        i_window_range_select = '{'{12'h020, 4'h0}, '{12'h020, 4'h1}, '{12'h011, 4'h0},
            '{12'h010, 4'h2}};
        for (int k = 0; k < 5; k++) begin
            tp.cs = CS_IDLE ^ 5'(1 << k);
            acc(wa[k], 1'b1, 1'b0, 16'(rnd()));
            acc(wa[k], 1'b0, 1'b0, 16'h0000);
        end
        tp.cs = 5'h1e;
        $display("test windows done");
        // the 1M setting is the four-line limit software keeps for shared pins
        for (int s = 0; s < 4; s++) begin
            i_seg_size = 2'(s);
            tp.seg = segx[s];
            acc(24'hab0050, 1'b0, 1'b0, 16'h0000);
            chk("seg", {8'h00, 8'hab & segx[s]}, {8'h00, o_pins.seg});
        end
        i_seg_size = SEG_16M;
        tp.seg = 8'hff;
        i_default_bus_config = mk(1'b0, MODE_DEMUX16, 7'h00, 1'b1);
        acc(24'h030060, 1'b0, 1'b0, 16'h0000);
        base = lat;
        wait_n = 4'h6;
        acc(24'h030060, 1'b0, 1'b0, 16'h0000);
        chk("ready_latency", 16'(base + 6), 16'(lat));
        wait_n = 4'h0;
        $display("test ready done");
        i_single_chip = 1'b1;
        tp = '{1'b1, 1'b0, 16'h0000, 5'h1f, 8'h00, 1'b0};
        acc(24'h030010, 1'b0, 1'b0, 16'h0000);
        i_single_chip = 1'b0;
        tp = '{1'b0, 1'b0, 16'h0000, 5'h1e, 8'hff, 1'b1};
        i_arbitration_enable = 1'b1;
        fork
            acc(24'h030010, 1'b0, 1'b0, 16'h0000);
            begin
                repeat (2) @(negedge i_clk);
                i_hold_n = 1'b0;
            end
        join
        repeat (3) @(negedge i_clk);
        chk("ack_n", 16'h0000, {15'h0000, o_hold_acknowledge_n});
        chk("first_bus_port_oe", 16'h0000, o_pins.first_bus_port_oe);
        chk("ctrl_oe", 16'h0000, {15'h0000, o_pins.ctrl_oe});
        fork
            acc(24'h030070, 1'b1, 1'b0, 16'(rnd()));
            begin
                repeat (4) @(negedge i_clk);
                chk("bus_request_out_n", 16'h0000, {15'h0000, o_bus_request_out_n});
                i_hold_n = 1'b1;
            end
        join
        chk("ack_n", 16'h0001, {15'h0000, o_hold_acknowledge_n});
        $display("test master hold done");
        i_ack_pin_direction_bit = 1'b1;
        repeat (3) @(negedge i_clk);
        chk("ack_oe", 16'h0000, {15'h0000, o_hold_acknowledge_oe});
        fork
            acc(24'h030070, 1'b0, 1'b0, 16'h0000);
            begin
                repeat (4) @(negedge i_clk);
                chk("bus_request_out_n", 16'h0000, {15'h0000, o_bus_request_out_n});
                chk("second_bus_port_oe", 16'h0000, {15'h0000, o_pins.second_bus_port_oe});
                i_hold_acknowledge_n = 1'b0;
            end
        join
        i_ack_pin_direction_bit = 1'b0;
        i_arbitration_enable = 1'b0;
        i_hold_acknowledge_n = 1'b1;
        $display("test slave done");
        i_system_config_reg = 16'h0040;
        i_req_addr = 24'h020040;
        repeat (3) @(negedge i_clk);
        chk("cs_n", 16'h000f, {11'h000, o_pins.cs_n});
        i_req_addr = 24'h030040;
        repeat (3) @(negedge i_clk);
        chk("cs_n", 16'h001e, {11'h000, o_pins.cs_n});
        i_system_config_reg = 16'h0000;
        repeat (3) @(negedge i_clk);
        chk("cs_n", 16'h001f, {11'h000, o_pins.cs_n});
        $display("test unlatched done");
        test_done();
    end
endmodule
